// ### sim/clock_mode_checks_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module clock_mode_checks #(
    parameter int XTAL_SETTLE_CYCLES = 54400
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic halt_enter,
    input wire logic [7:0] periph_clock_en,
    input wire logic first_kbd_port_clock_en,
    input wire logic debug_unit_clock_en,
    input wire logic cpu_clock_output_en,
    input wire logic rc_osc_on,
    input wire logic crystal_osc_on,
    input wire logic source_select_out,
    input wire logic [1:0] slow_divide_out,
    input wire logic cpu_tick,
    input wire logic calib_run
);
    logic [7:0] halt_hist;
    // Recent halt requests excuse forced enable changes
    always_ff @(posedge clk) begin
        halt_hist <= {halt_hist[6:0], halt_enter};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr_b;
        wr_en && addr == 8'h2d;
    endsequence
    a_gate_a_copy: assert property (wr_en && addr == 8'h2c
        |-> ##2 periph_clock_en == ($past(wdata, 2) & 8'hef)) else $error("gate a wrong");
    a_clkout_follow: assert property (s_wr_b
        |-> ##2 cpu_clock_output_en == $past(wdata[7], 2)) else $error("clock out wrong");
    a_kbd_follow: assert property (s_wr_b
        |-> ##2 first_kbd_port_clock_en == $past(wdata[5], 2)) else $error("kbd wrong");
    a_debug_sticky: assert property (debug_unit_clock_en |=> debug_unit_clock_en)
        else $error("debug enable dropped");
    a_rc_guard: assert property ($fell(rc_osc_on)
        |-> $past(source_select_out) || |halt_hist) else $error("rc dropped while used");
    a_xtal_guard: assert property ($fell(crystal_osc_on)
        |-> !$past(source_select_out) || |halt_hist) else $error("xtal dropped while used");
    a_one_enable: assert property ($changed(rc_osc_on) && $changed(crystal_osc_on)
        |-> |halt_hist) else $error("both enables changed");
    a_src_enabled: assert property (source_select_out |-> crystal_osc_on)
        else $error("xtal selected while off");
    a_cal_ends: assert property ($rose(calib_run) |-> ##[1:70] !calib_run)
        else $error("calibration never ends");
    a_full_rate: assert property (!$past(sys_rst, 2) && slow_divide_out == 2'b00
        && $past(slow_divide_out) == 2'b00 |-> cpu_tick) else $error("tick missing");
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not idle");
endmodule // clock_mode_checks
bind clock_mode_control clock_mode_checks #(.XTAL_SETTLE_CYCLES(XTAL_SETTLE_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .halt_enter(halt_enter), .periph_clock_en(periph_clock_en),
    .first_kbd_port_clock_en(first_kbd_port_clock_en), .rc_osc_on(rc_osc_on),
    .debug_unit_clock_en(debug_unit_clock_en), .cpu_clock_output_en(cpu_clock_output_en),
    .crystal_osc_on(crystal_osc_on), .source_select_out(source_select_out),
    .slow_divide_out(slow_divide_out), .cpu_tick(cpu_tick), .calib_run(calib_run));
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, sys_rst = 1, wr_en = 0, rd_en = 0;
    logic halt_enter = 0, wake_ext = 0, wake_other = 0, calib_finish = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rv;
    wire [7:0] rdata, pce;
    wire cpu_tick, calib_run, dbg, clkout, src;
    wire kbd1, kbd0;
    wire [6:0] gbits;
    int num_errors = 0, total_checks = 0, cnt;
    // Free running clock
    always #12.5 clk = ~clk;
    clock_mode_control #(.XTAL_SETTLE_CYCLES(50)) uut (
        .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .halt_enter(halt_enter), .wake_ext(wake_ext),
        .wake_other(wake_other), .calib_finish(calib_finish), .periph_clock_en(pce),
        .receiver_one_clock_en(gbits[6]), .receiver_zero_clock_en(gbits[5]),
        .radio_dsp_clock_en(gbits[4]), .time_base_clock_en(gbits[3]), .spi_clock_en(gbits[2]),
        .wide_timer_clock_en(gbits[1]), .usb_clock_en(gbits[0]),
        .second_kbd_port_clock_en(kbd1), .first_kbd_port_clock_en(kbd0), .rc_osc_on(),
        .debug_unit_clock_en(dbg), .cpu_clock_output_en(clkout), .crystal_osc_on(),
        .source_select_out(src), .slow_divide_out(), .cpu_tick(cpu_tick), .calib_run(calib_run));
    task automatic end_of_test;
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, exp, input logic [7:0] m = 8'hff);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 rv = rdata;
        chk($sformatf("reg %h", a), rv & m, exp);
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(8'h2c, 8'h00);
        rchk(8'h2d, 8'h00);
        rchk(8'h2e, 8'h14);
        rchk(8'h2f, 8'h00);
        wr(8'h2c, 8'ha5);
        rchk(8'h2c, 8'ha5);
        chk("gate_a", pce, 8'ha5);
        chk("gate_a_bits", {gbits[6:4], 1'b0, gbits[3:0]}, 8'ha5);
        wr(8'h2d, 8'hb0);
        rchk(8'h2d, 8'hb0);
        chk("gate_b_bits", {clkout, kbd1, kbd0, dbg, 4'h0}, 8'hb0);
        wr(8'h2d, 8'h40);
        rchk(8'h2d, 8'h50);
        chk("clkout_dbg", {6'h00, clkout, dbg}, 8'h01);
        chk("kbd", {6'h00, kbd1, kbd0}, 8'h02);
        wr(8'h2e, 8'h1b);
        rchk(8'h2e, 8'h17);
        wr(8'h2e, 8'h1d);
        repeat (460) @(posedge clk);
        rchk(8'h2e, 8'h3d);
        wr(8'h2e, 8'h18);
        rchk(8'h2e, 8'h3c);
        wr(8'h2e, 8'h0c);
        wr(8'h2e, 8'h04);
        rchk(8'h2e, 8'h2c);
        wr(8'h2e, 8'h08);
        wr(8'h2e, 8'h18);
        rchk(8'h2e, 8'h28);
        for (int k = 0; k < 4; k++) begin
            wr(8'h2e, 8'h08 | k[7:0]);
            repeat (4) @(posedge clk);
            cnt = 0;
            repeat (64) begin
                @(posedge clk);
                #1 cnt += cpu_tick;
            end
            chk("ticks", cnt[7:0], 8'h40 >> k);
        end
        wr(8'h2e, 8'h48);
        rchk(8'h2e, 8'h68);
        chk("cal_run", {7'h00, calib_run}, 8'h01);
        repeat (80) @(posedge clk);
        rchk(8'h2e, 8'ha8);
        wr(8'h2e, 8'h48);
        calib_finish <= 1'b1;
        repeat (8) @(posedge clk);
        calib_finish <= 1'b0;
        rchk(8'h2e, 8'ha8);
        wr(8'h2e, 8'h0c);
        rchk(8'h2e, 8'h8c);
        repeat (60) @(posedge clk);
        wr(8'h2e, 8'h1c);
        rchk(8'h2e, 8'hbc);
        chk("src", {7'h00, src}, 8'h01);
        wr(8'h2e, 8'h14);
        rchk(8'h2e, 8'hb4);
        wr(8'h2e, 8'h0c);
        rchk(8'h2e, 8'h8c);
        @(posedge clk) halt_enter <= 1'b1;
        repeat (10) @(posedge clk);
        halt_enter <= 1'b0;
        rchk(8'h2e, 8'h80, 8'hdf);
        @(posedge clk) wake_other <= 1'b1;
        repeat (10) @(posedge clk);
        wake_other <= 1'b0;
        rchk(8'h2e, 8'h80, 8'hdf);
        @(posedge clk) wake_ext <= 1'b1;
        repeat (10) @(posedge clk);
        wake_ext <= 1'b0;
        rchk(8'h2e, 8'h88, 8'hdf);
        end_of_test;
    end
    // Watchdog against a hang
    initial begin
        #100000;
        num_errors++;
        end_of_test;
    end
endmodule // tb
`default_nettype wire

// ### verilog/clock_mode_control.v
// Summary of operation
// - Gate A bits enable individual peripheral clocks
// - Gate B bits 6,5 enable keyboard ports
// - Gate B bit 7 drives CPU clock out
// - Debug clock enable sticky until reset
// - Calibration done set by hardware, cleared on start
// - Calibration start self-clears, works with RC off
// - Settled flag clears on enable, fixed delay
// - Source select chooses RC or crystal
// - RC enable cleared only while crystal selected
// - Crystal enable cleared only while RC selected
// - Slow field divides clock by 1,2,4,8
// - Changing both enables at once is rejected
// - Selecting a disabled source is ignored
// - Disabling selected oscillator is ignored
// - Halt entry selects RC, disables both
// - Wake-up from halt selects RC
// - Source change may drop CPU clock pulses
// - Reset values 00h, 00h, 14h
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "clock_mode_defs.vh"

module clock_mode_control #(
    parameter XTAL_SETTLE_CYCLES = `XTAL_SETTLE_CYC
) (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire halt_enter,
    input wire wake_ext,
    input wire wake_other,
    input wire calib_finish,
    output reg [7:0] periph_clock_en,
    output reg receiver_one_clock_en,
    output reg receiver_zero_clock_en,
    output reg radio_dsp_clock_en,
    output reg time_base_clock_en,
    output reg spi_clock_en,
    output reg wide_timer_clock_en,
    output reg usb_clock_en,
    output reg second_kbd_port_clock_en,
    output reg first_kbd_port_clock_en,
    output reg debug_unit_clock_en,
    output reg cpu_clock_output_en,
    output reg rc_osc_on,
    output reg crystal_osc_on,
    output reg source_select_out,
    output reg [1:0] slow_divide_out,
    output reg cpu_tick,
    output reg calib_run
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RC = 3'b010;
    localparam [2:0] ST_XTAL = 3'b100;
    // Full-width copies so each count is cut to its counter on purpose
    // Limit: settle counts above 16 bits do not fit the counter
    localparam [31:0] RC_CYC_FULL = `RC_SETTLE_CYC;
    localparam [31:0] XTAL_CYC_FULL = XTAL_SETTLE_CYCLES;
    localparam [31:0] CAL_CYC_FULL = `CAL_CYC;
    localparam [15:0] RC_CYC = RC_CYC_FULL[15:0];
    localparam [15:0] XTAL_CYC = XTAL_CYC_FULL[15:0];
    localparam [6:0] CAL_CYC = CAL_CYC_FULL[6:0];
    // Mode register reset image, bits picked by field position
    localparam [7:0] RST_MODE_V = `RST_MODE;

    // Software-visible state and internal counters
    reg [7:0] gate_a;
    reg [7:0] gate_b;
    reg calibration_done;
    reg calibration_start;
    reg oscillator_settled;
    reg source_select;
    reg rc_osc_enable;
    reg crystal_osc_enable;
    reg [1:0] slow_divide_select;
    reg [2:0] settle_state;
    reg [15:0] settle_cnt;
    reg [6:0] cal_cnt;
    reg [2:0] div_cnt;
    // Synchroniser and edge-detect stages
    reg halt_sync1, halt_sync2, halt_prev;
    reg ext_sync1, ext_sync2, ext_prev;
    reg oth_sync1, oth_sync2, oth_prev;
    reg cal_sync1, cal_sync2;
    // Next values under the write restrictions
    reg next_rc_en;
    reg next_xtal_en;
    reg next_src;
    reg rc_rise;
    reg xtal_rise;

    // Register address match
    function hit;
        input [7:0] a;
        input [7:0] target;
        begin
            hit = (a == target);
        end
    endfunction

    wire wr_a = wr_en && hit(addr, `ADDR_GATE_A);
    wire wr_b = wr_en && hit(addr, `ADDR_GATE_B);
    wire wr_m = wr_en && hit(addr, `ADDR_MODE);
    // Event pins act on their rising edge once synchronised
    wire halt_edge = halt_sync2 && !halt_prev;
    wire wake_edge = (ext_sync2 && !ext_prev) || (oth_sync2 && !oth_prev);
    wire ext_edge = ext_sync2 && !ext_prev;

    // Two-stage synchronisers for external event pins
    // Edge stages reset low like the idle pins, so no false edge
    always @(posedge clk) begin
        if (sys_rst) begin
            halt_sync1 <= 1'b0;
            halt_sync2 <= 1'b0;
            halt_prev <= 1'b0;
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
            oth_sync1 <= 1'b0;
            oth_sync2 <= 1'b0;
            oth_prev <= 1'b0;
            cal_sync1 <= 1'b0;
            cal_sync2 <= 1'b0;
        end else begin
            halt_sync1 <= halt_enter;
            halt_sync2 <= halt_sync1;
            halt_prev <= halt_sync2;
            ext_sync1 <= wake_ext;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
            oth_sync1 <= wake_other;
            oth_sync2 <= oth_sync1;
            oth_prev <= oth_sync2;
            cal_sync1 <= calib_finish;
            cal_sync2 <= cal_sync1;
        end
    end

    // Software oscillator update under switching restrictions
    // Rejected enable changes leave select and slow fields free
    always @* begin
        next_rc_en = rc_osc_enable;
        next_xtal_en = crystal_osc_enable;
        next_src = source_select;
        if (wr_m) begin
            if ((wdata[`MD_RC_OSC_ENABLE] != rc_osc_enable) &&
                (wdata[`MD_XTALEN] != crystal_osc_enable)) begin
                next_rc_en = rc_osc_enable;
                next_xtal_en = crystal_osc_enable;
            end else begin
                // Clear only allowed while the other source drives the CPU
                if (wdata[`MD_RC_OSC_ENABLE] || source_select)
                    next_rc_en = wdata[`MD_RC_OSC_ENABLE];
                if (wdata[`MD_XTALEN] || !source_select)
                    next_xtal_en = wdata[`MD_XTALEN];
            end
            // Selection checks the enable that this write leaves in force,
            // so one write may start a source and select it
            if (wdata[`MD_SRCSEL] ? next_xtal_en : next_rc_en)
                next_src = wdata[`MD_SRCSEL];
        end
        rc_rise = next_rc_en && !rc_osc_enable;
        xtal_rise = next_xtal_en && !crystal_osc_enable;
    end

    // Mode register and gating registers
    always @(posedge clk) begin
        if (sys_rst) begin
            gate_a <= `RST_GATE_A;
            gate_b <= `RST_GATE_B;
            calibration_done <= RST_MODE_V[`MD_CALDONE];
            calibration_start <= RST_MODE_V[`MD_CALSTART];
            source_select <= RST_MODE_V[`MD_SRCSEL];
            rc_osc_enable <= RST_MODE_V[`MD_RC_OSC_ENABLE];
            crystal_osc_enable <= RST_MODE_V[`MD_XTALEN];
            slow_divide_select <= RST_MODE_V[`MD_SLOW_HI:`MD_SLOW_LO];
            cal_cnt <= 7'h00;
        end else begin
            if (wr_a)
                gate_a <= wdata & `GA_MASK;
            // Debug enable only ever sets; reset alone clears it
            if (wr_b)
                gate_b <= (wdata & `GB_MASK) | (gate_b & (8'h01 << `GB_DEBUG));
            // Halt beats wake, and wake beats software, in one cycle
            if (halt_edge) begin
                source_select <= 1'b0;
                rc_osc_enable <= 1'b0;
                crystal_osc_enable <= 1'b0;
            end else if (wake_edge) begin
                source_select <= 1'b0;
                // External wake restarts the RC oscillator
                if (ext_edge)
                    rc_osc_enable <= 1'b1;
            end else begin
                source_select <= next_src;
                rc_osc_enable <= next_rc_en;
                crystal_osc_enable <= next_xtal_en;
            end
            if (wr_m)
                slow_divide_select <= wdata[`MD_SLOW_HI:`MD_SLOW_LO];
            // Calibration runs regardless of the RC enable
            // A new start restarts the run; the pin may end it early
            if (wr_m && wdata[`MD_CALSTART]) begin
                calibration_start <= 1'b1;
                calibration_done <= 1'b0;
                cal_cnt <= CAL_CYC;
            end else if (calibration_start) begin
                if (cal_sync2 || cal_cnt == 7'h00) begin
                    calibration_start <= 1'b0;
                    calibration_done <= 1'b1;
                end else begin
                    cal_cnt <= cal_cnt - 7'h01;
                end
            end
        end
    end

    // Stabilisation delay counter
    always @(posedge clk) begin
        if (sys_rst) begin
            settle_state <= ST_IDLE;
            settle_cnt <= 16'h0000;
            oscillator_settled <= RST_MODE_V[`MD_SETTLED];
        end else begin
            // Crystal count wins; one write never raises both enables
            if (!halt_edge && !wake_edge && (rc_rise || xtal_rise)) begin
                oscillator_settled <= 1'b0;
                settle_state <= xtal_rise ? ST_XTAL : ST_RC;
                settle_cnt <= xtal_rise ? XTAL_CYC : RC_CYC;
            end else if (!halt_edge && ext_edge && !rc_osc_enable) begin
                // Wake by external event starts the RC delay
                oscillator_settled <= 1'b0;
                settle_state <= ST_RC;
                settle_cnt <= RC_CYC;
            end else begin
                case (settle_state)
                    ST_IDLE: begin
                        settle_cnt <= 16'h0000;
                    end
                    ST_RC, ST_XTAL: begin
                        if (settle_cnt <= 16'h0001) begin
                            oscillator_settled <= 1'b1;
                            settle_state <= ST_IDLE;
                        end else begin
                            settle_cnt <= settle_cnt - 16'h0001;
                        end
                    end
                    default: begin
                        settle_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Slow-mode tick generator
    // Free-running count; the tick marks one cycle per group
    always @(posedge clk) begin
        if (sys_rst) begin
            div_cnt <= 3'b000;
            cpu_tick <= 1'b0;
        end else begin
            case (slow_divide_select)
                2'b00: cpu_tick <= 1'b1;
                2'b01: cpu_tick <= (div_cnt[0] == 1'b0);
                2'b10: cpu_tick <= (div_cnt[1:0] == 2'b00);
                default: cpu_tick <= (div_cnt == 3'b000);
            endcase
            div_cnt <= div_cnt + 3'b001;
        end
    end

    // Registered enables for glitch-free downstream gating cells
    // Downstream clock mux drops pulses while the select moves
    always @(posedge clk) begin
        if (sys_rst) begin
            periph_clock_en <= 8'h00;
            receiver_one_clock_en <= 1'b0;
            receiver_zero_clock_en <= 1'b0;
            radio_dsp_clock_en <= 1'b0;
            time_base_clock_en <= 1'b0;
            spi_clock_en <= 1'b0;
            wide_timer_clock_en <= 1'b0;
            usb_clock_en <= 1'b0;
            second_kbd_port_clock_en <= 1'b0;
            first_kbd_port_clock_en <= 1'b0;
            debug_unit_clock_en <= 1'b0;
            cpu_clock_output_en <= 1'b0;
            rc_osc_on <= 1'b0;
            crystal_osc_on <= 1'b1;
            source_select_out <= 1'b1;
            slow_divide_out <= 2'b00;
            calib_run <= 1'b0;
        end else begin
            periph_clock_en <= gate_a;
            receiver_one_clock_en <= gate_a[`GA_RX1];
            receiver_zero_clock_en <= gate_a[`GA_RX0];
            radio_dsp_clock_en <= gate_a[`GA_RFDSP];
            time_base_clock_en <= gate_a[`GA_TBU];
            spi_clock_en <= gate_a[`GA_SPI];
            wide_timer_clock_en <= gate_a[`GA_T16];
            usb_clock_en <= gate_a[`GA_USB];
            second_kbd_port_clock_en <= gate_b[`GB_KBD1];
            first_kbd_port_clock_en <= gate_b[`GB_KBD0];
            debug_unit_clock_en <= gate_b[`GB_DEBUG];
            cpu_clock_output_en <= gate_b[`GB_CLKOUT];
            rc_osc_on <= rc_osc_enable;
            crystal_osc_on <= crystal_osc_enable;
            source_select_out <= source_select;
            slow_divide_out <= slow_divide_select;
            calib_run <= calibration_start;
        end
    end

    // Read data one cycle after the strobe
    // Unmapped addresses and idle cycles read zero
    always @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            if (hit(addr, `ADDR_GATE_A))
                rdata <= gate_a;
            else if (hit(addr, `ADDR_GATE_B))
                rdata <= gate_b;
            else if (hit(addr, `ADDR_MODE))
                rdata <= {calibration_done, calibration_start, oscillator_settled,
                          source_select, rc_osc_enable, crystal_osc_enable,
                          slow_divide_select};
            else
                rdata <= 8'h00;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // clock_mode_control
`default_nettype wire

// ### verilog/clock_mode_defs.vh
`ifndef CLOCK_MODE_DEFS_VH
`define CLOCK_MODE_DEFS_VH

// Register byte addresses
`define ADDR_GATE_A 8'h2c
`define ADDR_GATE_B 8'h2d
`define ADDR_MODE 8'h2e

// Reset values
`define RST_GATE_A 8'h00
`define RST_GATE_B 8'h00
`define RST_MODE 8'h14

// Gate A fields
`define GA_RX1 7
`define GA_RX0 6
`define GA_RFDSP 5
`define GA_TBU 3
`define GA_SPI 2
`define GA_T16 1
`define GA_USB 0
`define GA_MASK 8'hef

// Gate B fields
`define GB_CLKOUT 7
`define GB_KBD1 6
`define GB_KBD0 5
`define GB_DEBUG 4
`define GB_MASK 8'hf0

// Mode register fields
`define MD_CALDONE 7
`define MD_CALSTART 6
`define MD_SETTLED 5
`define MD_SRCSEL 4
`define MD_RC_OSC_ENABLE 3
`define MD_XTALEN 2
`define MD_SLOW_HI 1
`define MD_SLOW_LO 0

// Timing
`define CLK_PERIOD_PS 25000
`define RC_SETTLE_PS 11200000
`define XTAL_SETTLE_US 1360
// Least times round up
`define RC_SETTLE_CYC ((`RC_SETTLE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define XTAL_SETTLE_CYC ((`XTAL_SETTLE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CAL_CYC 64

`endif
